// >>> core/fmgd_pkg.sv
// Package for the FSK gain and demodulator control block.
// Assumes a 100 MHz system clock standing in for the crystal reference.
package fmgd_pkg;

  // ****************
  // Bus map
  // ****************
  localparam int          NUM_WORDS   = 11;
  localparam logic [7:0]  ADDR_CENTER = 8'h2c;
  localparam logic [7:0]  ADDR_STATUS = 8'h30;
  localparam logic [7:0]  ADDR_LAST_W = 8'h28;

  // ****************
  // Field positions
  // ****************
  localparam int TXRX_BIT     = 27;  // Word 0
  localparam int LPF_BW_LSB   = 22;  // Word 1
  localparam int PA_EN_BIT    = 4;   // Word 2
  localparam int MOD_LSB      = 6;
  localparam int PA_PWR_LSB   = 9;
  localparam int MODNUM_LSB   = 15;
  localparam int PA_BIAS_LSB  = 30;
  localparam int OFS_DIV_LSB  = 4;   // Word 3
  localparam int SEQ_DIV_LSB  = 8;
  localparam int BITCLK_LSB   = 16;
  localparam int DEMOD_LSB    = 4;   // Word 4
  localparam int POST_BW_LSB  = 6;
  localparam int CORR_BW_LSB  = 4;   // Word 6
  localparam int NOISE_BIT    = 15;
  localparam int MIXER_BIT    = 18;
  localparam int CAL_GO_BIT   = 19;
  localparam int LPF_DIV_LSB  = 20;
  localparam int AGC_LO_LSB   = 4;   // Word 9
  localparam int AGC_HI_LSB   = 11;
  localparam int AUTO_A_BIT   = 18;
  localparam int AUTO_B_BIT   = 19;
  localparam int AMP_G_LSB    = 20;
  localparam int FILT_G_LSB   = 22;
  localparam int AGC_WAIT_LSB = 0;   // Word 10

  // ****************
  // Reset values and codes
  // ****************
  localparam logic [31:0] W9_RESET  = 32'h0002_31e0; // Thresholds 70 / 30
  localparam logic [31:0] W10_RESET = 32'h0000_000a; // Gain wait count 10
  localparam logic [31:0] W_ZERO    = 32'h0000_0000;
  localparam logic [2:0]  MOD_FSK   = 3'h0;
  localparam logic [1:0]  DEMOD_LIN = 2'h0;
  localparam logic [1:0]  DEMOD_COR = 2'h1;
  localparam logic [1:0]  OFS_DIV4  = 2'h0;
  localparam logic [1:0]  OFS_DIV8  = 2'h1;
  localparam logic [4:0]  HALF4     = 5'h02;
  localparam logic [4:0]  HALF8     = 5'h04;
  localparam logic [4:0]  HALF16    = 5'h08;
  localparam logic [2:0]  GAIN_MAX  = 3'h5;   // Six gain steps, 0 = highest
  localparam logic [4:0]  PHASE_MID = 5'h10;  // Sample point of 32 phases

  // ****************
  // Timing
  // ****************
  localparam int CLK_MHZ     = 100;
  localparam int CAL_TIME_US = 200;
  localparam int CAL_CYCLES  = CAL_TIME_US * CLK_MHZ;

  // ****************
  // Types
  // ****************
  typedef enum logic {CAL_IDLE, CAL_RUN} fmgd_cal_type;

  typedef struct packed {
    logic       lna_short;
    logic       amp_noise_mode_bit;
    logic       mixer_linear;
    logic [1:0] front_amp_gain_field;
    logic [1:0] filter_gain;
    logic [1:0] lpf_bw;
  } fmgd_front_type;

  typedef struct packed {
    logic       pa_enable;
    logic [5:0] pa_power;
    logic [1:0] pa_bias;
    logic [2:0] mod_scheme;
    logic [22:0] synth_div;
  } fmgd_tx_type;

endpackage : fmgd_pkg

// >>> core/fmgd_post_filter.sv
// Second-order post-detection low-pass filter, two first-order stages.
// Assumes samples arrive as one-cycle strobes on the system clock.
`timescale 1ns/1ps
module fmgd_post_filter
  import fmgd_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               in_valid,
  input  wire logic signed [11:0] in_sample,
  input  wire logic        [9:0]  bw,
  output logic                    out_valid,
  output logic signed [11:0]      out_sample
);

  logic signed [21:0] s1_reg;
  logic signed [21:0] s2_reg;
  logic signed [21:0] d1;
  logic signed [21:0] d2;
  logic signed [32:0] p1;
  logic signed [32:0] p2;

  // Coefficient bw/1024 per stage; large bw means a wider filter
  always_comb
  begin
    d1 = {in_sample, 10'h000} - s1_reg;
    d2 = s1_reg - s2_reg;
    p1 = d1 * $signed({1'b0, bw});
    p2 = d2 * $signed({1'b0, bw});
  end

  // Both stages step on the same strobe, so latency is two samples
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_reg    <= 22'sh000000;
      s2_reg    <= 22'sh000000;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        s1_reg <= s1_reg + p1[31:10];
        s2_reg <= s2_reg + p2[31:10];
      end
    end
  end

  assign out_sample = s2_reg[21:10];

endmodule : fmgd_post_filter

// >>> core/fmgd_ctrl.sv
// Digital control of an FSK transceiver: APB registers, transmit
// settings, front-end gain control, calibration and bit recovery.
// Assumes the system clock stands in for the crystal and that the
// strength code and discriminator samples are synchronous to it.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps

// What this block does
// RL1: Output power comes from word 2 bits 14:9, never from data.
// RL2: Word 2 bits 31:30 hold amplifier bias; host keeps default.
// RL3: Clearing word 2 bit 4 turns the output stage off.
// RL4: FSK holds divider at centre and shifts it by each data bit.
// RL5: Deviation is comparison rate times 9-bit number over 2^14.
// RL6: Word 2 bits 8:6 select the modulation scheme.
// RL7: Word 0 bit 27 low selects transmit and shorts the amp input.
// RL8: Word 6 bit 15 sets amp noise mode, bit 18 mixer linearity.
// RL9: Amp gain is word 9 bits 21:20 or the gain loop's choice.
// RL10: Word 1 bits 23:22 set channel filter width 300/450/600 kHz.
// RL11: After a divider write, setting word 6 bit 19 runs calibration.
// RL12: Host leaves the block alone for 200 us of calibration.
// RL13: Seven-bit strength code feeds readback and the gain loop.
// RL14: Offset clock is the reference over 4, 8 or 16.
// RL15: Word 9 bits 18 and 19 enable the gain loop with thresholds.
// RL16: Thresholds reset to 30 and 70; host may set 15 and 79.
// RL17: Gain steps wait count times sequencer divider clock periods.
// RL18: Host turns code and gain readback into dBm itself.
// RL19: Word 4 bits 5:4 at 01 select the correlator.
// RL20: Discriminator output passes a second-order low-pass filter.
// RL21: Correlator bits are sliced at a threshold of zero.
// RL22: A 32-phase loop resamples bits with about 2 percent slack.
// RL23: Word 6 bits 13:4 give the correlator bandwidth.
// RL24: Word 4 bits 5:4 at 00 select the linear demodulator.
// RL25: Gain loop steps down above high, up below low threshold.
module fmgd_ctrl
  import fmgd_pkg::*;
#(
  parameter int CAL_CYCLES_P = CAL_CYCLES
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Transmit side
  input  wire logic               transmit_bit_input,
  output fmgd_tx_type             tx_ctrl,
  // Receive front end
  input  wire logic [6:0]         strength_code,
  output fmgd_front_type          front_ctrl,
  output logic                    offset_clock,
  output logic [8:0]              lpf_divider,
  output logic                    cal_busy,
  // Demodulator
  input  wire logic               corr_valid,
  input  wire logic signed [11:0] corr_sample,
  input  wire logic               lin_valid,
  input  wire logic signed [11:0] lin_sample,
  output logic [9:0]              correlator_bandwidth,
  output logic                    rx_bit,
  output logic                    rx_bit_valid
);

  // ****************
  // Register file
  // ****************
  logic [31:0]  cfg_reg [NUM_WORDS];
  logic [22:0]  center_reg;
  logic         access;
  logic         wr_take;
  logic         mapped;
  logic [7:0]   word_idx;

  // Registered pready; writes land at the edge that samples it high
  assign access   = psel & penable & ~pready;
  assign wr_take  = psel & penable & pready & pwrite;
  assign word_idx = {2'h0, paddr[7:2]};
  assign mapped   = (paddr[1:0] == 2'h0) &&
                    ((paddr <= ADDR_LAST_W) || (paddr == ADDR_CENTER) ||
                     (paddr == ADDR_STATUS));

  // One write process per configuration word
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++)
    begin : g_word
      localparam logic [31:0] RV = (gi == 9)  ? W9_RESET :
                                   (gi == 10) ? W10_RESET : W_ZERO;
      always_ff @(posedge clk_sys)
      begin
        if (rst)
          cfg_reg[gi] <= RV;                         // [RL16]
        else if (wr_take && mapped && word_idx == 8'(gi))
          cfg_reg[gi] <= pwdata;
      end
    end
  endgenerate

  // Centre divider value, integer and 15-bit fraction
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      center_reg <= 23'h000000;
    else if (wr_take && paddr == ADDR_CENTER)
      center_reg <= pwdata[22:0];
  end

  // ****************
  // Field decode
  // ****************
  logic       rx_mode;
  logic [1:0] ofs_sel;
  logic [7:0] seq_div;
  logic [9:0] bitclk_div;
  logic [1:0] demod_sel;
  logic [9:0] post_bw;
  logic [6:0] thr_lo;
  logic [6:0] thr_hi;
  logic       agc_on;
  logic [7:0] wait_cnt;
  logic [8:0] mod_num;

  assign rx_mode    = cfg_reg[0][TXRX_BIT];
  assign ofs_sel    = cfg_reg[3][OFS_DIV_LSB +: 2];
  assign seq_div    = cfg_reg[3][SEQ_DIV_LSB +: 8];
  assign bitclk_div = cfg_reg[3][BITCLK_LSB +: 10];
  assign demod_sel  = cfg_reg[4][DEMOD_LSB +: 2];
  assign post_bw    = cfg_reg[4][POST_BW_LSB +: 10];
  assign thr_lo     = cfg_reg[9][AGC_LO_LSB +: 7];
  assign thr_hi     = cfg_reg[9][AGC_HI_LSB +: 7];
  assign agc_on     = cfg_reg[9][AUTO_A_BIT] & cfg_reg[9][AUTO_B_BIT];
  assign wait_cnt   = cfg_reg[10][AGC_WAIT_LSB +: 8];
  assign mod_num    = cfg_reg[2][MODNUM_LSB +: 9];

  // ****************
  // Transmit settings
  // ****************
  // A 2^-14 step is two steps of the 2^-15 fraction, hence the shift
  logic [22:0] dev_step;
  assign dev_step = {13'h0000, mod_num, 1'b0};       // [RL5]

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tx_ctrl <= '0;
    else
    begin
      tx_ctrl.pa_enable  <= cfg_reg[2][PA_EN_BIT];   // [RL3]
      tx_ctrl.pa_power   <= cfg_reg[2][PA_PWR_LSB +: 6]; // [RL1]
      tx_ctrl.pa_bias    <= cfg_reg[2][PA_BIAS_LSB +: 2]; // [RL2]
      tx_ctrl.mod_scheme <= cfg_reg[2][MOD_LSB +: 3]; // [RL6]
      // Data bit moves only the divider, never the power setting
      if (!rx_mode && cfg_reg[2][MOD_LSB +: 3] == MOD_FSK)
        tx_ctrl.synth_div <= transmit_bit_input ?
                             center_reg + dev_step :
                             center_reg - dev_step;  // [RL4]
      else
        tx_ctrl.synth_div <= center_reg;
    end
  end

  // ****************
  // Filter calibration
  // ****************
  fmgd_cal_type cal_state_reg;
  logic [31:0]  cal_cnt_reg;
  logic         cal_go;

  assign cal_go = wr_take && mapped && word_idx == 8'h06 && pwdata[CAL_GO_BIT];

  // Runs untouched; a second start while busy is ignored
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cal_state_reg <= CAL_IDLE;
      cal_cnt_reg   <= 32'h0000_0000;
    end
    else
    begin
      case (cal_state_reg)
        CAL_IDLE:
          if (cal_go)
          begin
            cal_state_reg <= CAL_RUN;                // [RL11]
            cal_cnt_reg   <= 32'(CAL_CYCLES_P - 1);
          end
        CAL_RUN:
          if (cal_cnt_reg == 32'h0000_0000)
            cal_state_reg <= CAL_IDLE;               // [RL12]
          else
            cal_cnt_reg <= cal_cnt_reg - 32'h0000_0001;
        default:
          cal_state_reg <= CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cal_busy    <= 1'b0;
      lpf_divider <= 9'h000;
    end
    else
    begin
      cal_busy    <= (cal_state_reg == CAL_RUN) || cal_go;
      lpf_divider <= cfg_reg[6][LPF_DIV_LSB +: 9];
    end
  end

  // ****************
  // Offset correction clock
  // ****************
  logic [4:0] ofs_cnt_reg;
  logic [4:0] ofs_half;

  always_comb
  begin
    case (ofs_sel)
      OFS_DIV4: ofs_half = HALF4;
      OFS_DIV8: ofs_half = HALF8;
      default:  ofs_half = HALF16;
    endcase
  end

  // Toggling at half the divide keeps a 50:50 mark-space
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ofs_cnt_reg  <= 5'h01;
      offset_clock <= 1'b0;
    end
    else if (ofs_cnt_reg >= ofs_half)
    begin
      ofs_cnt_reg  <= 5'h01;
      offset_clock <= ~offset_clock;                 // [RL14]
    end
    else
      ofs_cnt_reg <= ofs_cnt_reg + 5'h01;
  end

  // ****************
  // Gain control loop
  // ****************
  logic [2:0]  gain_idx_reg;
  logic [15:0] agc_tmr_reg;
  logic [15:0] agc_period;
  logic [1:0]  auto_amp;
  logic [1:0]  auto_filt;

  assign agc_period = wait_cnt * seq_div;            // [RL17]

  // Step table from highest to lowest combined gain
  always_comb
  begin
    case (gain_idx_reg)
      3'h0:    begin auto_amp = 2'h3; auto_filt = 2'h2; end
      3'h1:    begin auto_amp = 2'h2; auto_filt = 2'h2; end
      3'h2:    begin auto_amp = 2'h2; auto_filt = 2'h1; end
      3'h3:    begin auto_amp = 2'h2; auto_filt = 2'h0; end
      3'h4:    begin auto_amp = 2'h1; auto_filt = 2'h0; end
      default: begin auto_amp = 2'h0; auto_filt = 2'h0; end
    endcase
  end

  // Decides only when the wait expires, so the loop settles between
  always_ff @(posedge clk_sys)
  begin
    if (rst || !agc_on)
    begin
      gain_idx_reg <= 3'h0;
      agc_tmr_reg  <= 16'h0000;
    end
    else if (agc_tmr_reg + 16'h0001 < agc_period)
      agc_tmr_reg <= agc_tmr_reg + 16'h0001;
    else
    begin
      agc_tmr_reg <= 16'h0000;
      if (strength_code > thr_hi && gain_idx_reg < GAIN_MAX)
        gain_idx_reg <= gain_idx_reg + 3'h1;         // [RL25]
      else if (strength_code < thr_lo && gain_idx_reg != 3'h0)
        gain_idx_reg <= gain_idx_reg - 3'h1;         // [RL15]
    end
  end

  // ****************
  // Front-end controls
  // ****************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      front_ctrl <= '0;
    else
    begin
      front_ctrl.lna_short          <= ~rx_mode;     // [RL7]
      front_ctrl.amp_noise_mode_bit <= cfg_reg[6][NOISE_BIT]; // [RL8]
      front_ctrl.mixer_linear       <= cfg_reg[6][MIXER_BIT]; // [RL8]
      front_ctrl.lpf_bw             <= cfg_reg[1][LPF_BW_LSB +: 2];
      front_ctrl.front_amp_gain_field <= agc_on ? auto_amp :
                             cfg_reg[9][AMP_G_LSB +: 2]; // [RL9]
      front_ctrl.filter_gain <= agc_on ? auto_filt :
                             cfg_reg[9][FILT_G_LSB +: 2];
    end
  end
  // Width code reaches the analog filter unchanged [RL10]

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      correlator_bandwidth <= 10'h000;
    else
      correlator_bandwidth <= cfg_reg[6][CORR_BW_LSB +: 10]; // [RL23]
  end

  // ****************
  // Demodulator path
  // ****************
  logic               dm_valid;
  logic signed [11:0] dm_sample;
  logic               pf_valid;
  logic signed [11:0] pf_sample;
  logic               sliced;

  // Correlator on 01, linear on 00; other codes leave the path idle
  always_comb
  begin
    dm_valid  = 1'b0;
    dm_sample = corr_sample;
    if (demod_sel == DEMOD_COR)
      dm_valid = corr_valid;                         // [RL19]
    else if (demod_sel == DEMOD_LIN)
    begin
      dm_valid  = lin_valid;                         // [RL24]
      dm_sample = lin_sample;
    end
  end

  fmgd_post_filter u_post (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .in_valid   (dm_valid),
    .in_sample  (dm_sample),
    .bw         (post_bw),                           // [RL20]
    .out_valid  (pf_valid),
    .out_sample (pf_sample)
  );

  // Centred levels let a fixed zero threshold ignore run length
  assign sliced = ~pf_sample[11];                    // [RL21]

  // ****************
  // Bit recovery loop
  // ****************
  logic [9:0] os_cnt_reg;
  logic       os_tick;
  logic [4:0] phase_reg;
  logic       last_bit_reg;
  logic       cur_bit_reg;

  assign os_tick = (os_cnt_reg >= bitclk_div);

  // Oversample tick at the bit recovery clock, 32 per bit
  always_ff @(posedge clk_sys)
  begin
    if (rst || os_tick)
      os_cnt_reg <= 10'h000;
    else
      os_cnt_reg <= os_cnt_reg + 10'h001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cur_bit_reg <= 1'b0;
    else if (pf_valid)
      cur_bit_reg <= sliced;
  end

  // An edge seen late holds the phase, early jumps two: 1/32 per edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phase_reg    <= 5'h00;
      last_bit_reg <= 1'b0;
    end
    else if (os_tick)
    begin
      last_bit_reg <= cur_bit_reg;
      if (cur_bit_reg != last_bit_reg && phase_reg != 5'h00)
        phase_reg <= (phase_reg < PHASE_MID) ? phase_reg :
                     phase_reg + 5'h02;              // [RL22]
      else
        phase_reg <= phase_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_bit       <= 1'b0;
      rx_bit_valid <= 1'b0;
    end
    else
    begin
      rx_bit_valid <= os_tick && phase_reg == PHASE_MID;
      if (os_tick && phase_reg == PHASE_MID)
        rx_bit <= cur_bit_reg;
    end
  end

  // ****************
  // Bus answer
  // ****************
  logic [31:0] rd_mux;

  // Status shows gain codes beside the live strength code
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (paddr == ADDR_STATUS)
      rd_mux = {20'h00000, cal_busy, front_ctrl.front_amp_gain_field,
                front_ctrl.filter_gain, strength_code}; // [RL13]
    else if (paddr == ADDR_CENTER)
      rd_mux = {9'h000, center_reg};
    else if (mapped)
      rd_mux = cfg_reg[word_idx[3:0]];
  end
  // Host forms dBm from status fields [RL18]

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped;
      if (access && !pwrite)
        prdata <= rd_mux;
    end
  end

endmodule : fmgd_ctrl

// >>> verif/fmgd_ctrl_asserts.sv
// Checker for bus timing, setting copies, calibration and bit pulses.
// Assumes it is bound into fmgd_ctrl and sees only its ports.
`timescale 1ns/1ps
module fmgd_ctrl_asserts
  import fmgd_pkg::*;
#(
  parameter int CAL_CYCLES_P = 20
)
(
  input wire logic           clk_sys,
  input wire logic           rst,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire fmgd_tx_type    tx_ctrl,
  input wire fmgd_front_type front_ctrl,
  input wire logic           cal_busy,
  input wire logic           rx_bit_valid
);
  // ****************
  // Helper counter
  // ****************
  logic [15:0] busy_cnt_reg;

  // Length of the busy run; cleared while idle
  always_ff @(posedge clk_sys)
  begin
    if (rst || !cal_busy)
      busy_cnt_reg <= 16'h0000;
    else
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****************
  // Properties
  // ****************
  ready_next_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  err_align_a: assert property (
    psel && penable && !pready && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned not refused");
  err_qual_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  power_hold_a: assert property (
    $changed(tx_ctrl.pa_power) |->
      $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("power moved without write");
  // Release of reset lets the copy follow the reset word once
  lna_hold_a: assert property (
    $changed(front_ctrl.lna_short) |-> $past(pready && pwrite) ||
      $past(pready && pwrite, 2) || $past(rst, 2) || $past(rst, 3))
    else $error("lna short moved without write");
  cal_len_a: assert property (
    $fell(cal_busy) |-> busy_cnt_reg == CAL_CYCLES_P + 1)
    else $error("calibration length wrong");
  bit_pulse_a: assert property (rx_bit_valid |=> !rx_bit_valid)
    else $error("bit strobe too long");

  cal_c: cover property ($fell(cal_busy));
  err_c: cover property (pslverr);
  bit_c: cover property (rx_bit_valid);
endmodule : fmgd_ctrl_asserts

bind fmgd_ctrl fmgd_ctrl_asserts #(.CAL_CYCLES_P(CAL_CYCLES_P))
  fmgd_ctrl_asserts_inst (.clk_sys, .rst, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .tx_ctrl, .front_ctrl, .cal_busy,
  .rx_bit_valid);

// >>> verif/fmgd_host_model.sv
// Host model: APB master cycles and the calibration start.
// Assumes one clock shared with the block.
`timescale 1ns/1ps
module fmgd_host_model
(
  input  wire logic        clk_sys,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  input  wire logic        cal_busy,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // Bus idle at time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // One access; request held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Start calibration, then keep off the bus until it ends
  task cal(input logic [31:0] d, output int n);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, 8'h18, d, q, e);
    @(posedge clk_sys);
    for (n = 0; cal_busy === 1'b1; n++)
      @(posedge clk_sys);
  endtask : cal
endmodule : fmgd_host_model

// >>> verif/tb.sv
// Bench for the FSK control block.
// Assumes fmgd_host_model drives the bus.
`timescale 1ns/1ps
module tb
  import fmgd_pkg::*;
;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               psel, penable, pwrite, pready, pslverr;
  logic               cal_busy, offset_clock, rx_bit, rx_bit_valid, e;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic               transmit_bit_input = 1'b0;
  logic [6:0]         strength_code = 7'h00;
  logic               corr_valid = 1'b0, lin_valid = 1'b0;
  logic signed [11:0] corr_sample, lin_sample, smp = 12'sh000;
  logic [8:0]         lpf_divider;
  logic [9:0]         correlator_bandwidth;
  fmgd_tx_type        tx_ctrl;
  fmgd_front_type     front_ctrl;
  int                 n_mismatch = 0, num_checks = 0, cyc = 0, n;

  always #5 clk_sys = ~clk_sys;

  // Samples every other cycle; the linear path sees the negation
  always @(posedge clk_sys)
  begin
    corr_valid <= !corr_valid;
    lin_valid <= !corr_valid;
    corr_sample <= smp;
    lin_sample <= -smp;
  end

  fmgd_ctrl #(.CAL_CYCLES_P(20)) fmgd_ctrl_inst (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .transmit_bit_input, .tx_ctrl, .strength_code, .front_ctrl,
    .offset_clock, .lpf_divider, .cal_busy, .corr_valid, .corr_sample,
    .lin_valid, .lin_sample, .correlator_bandwidth, .rx_bit,
    .rx_bit_valid);
  fmgd_host_model fmgd_host_model_inst (.clk_sys, .pready, .prdata,
    .pslverr, .cal_busy, .psel, .penable, .pwrite, .paddr, .pwdata);

  // ****************
  // Tasks
  // ****************
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, x, g);
    end
  endtask : chk

  // Write, then let the setting copies settle
  task wr(input logic [7:0] a, input logic [31:0] d);
    fmgd_host_model_inst.xfer(1'b1, a, d, q, e);
    repeat (3) @(posedge clk_sys);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x);
    fmgd_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
    chk("read", x, q);
  endtask : rd

  // Edges from one rise of the offset clock to the next
  task per(output int p);
    while (offset_clock !== 1'b0) @(posedge clk_sys);
    while (offset_clock !== 1'b1) @(posedge clk_sys);
    for (p = 0; offset_clock !== 1'b0; p++) @(posedge clk_sys);
    for (; offset_clock !== 1'b1; p++) @(posedge clk_sys);
  endtask : per

  task bit_chk(input logic [31:0] w4, input logic signed [11:0] s,
               input logic x);
    smp <= s;
    wr(8'h10, w4);
    repeat (300) @(posedge clk_sys);
    while (rx_bit_valid !== 1'b1) @(posedge clk_sys);
    chk("rx_bit", x, rx_bit);
  endtask : bit_chk

  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Hang guard; the tests need about 33000 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      results();
    end
  end

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h24, 32'h0002_31e0);
    rd(8'h28, W10_RESET);
    rd(8'h34, 32'h0);
    chk("unmapped", 32'h1, e);
    wr(8'h01, 32'h0);
    chk("misaligned", 32'h1, e);
    $display("test bus done");
    wr(8'h2c, 32'h0012_3456);
    wr(8'h00, W_ZERO);
    wr(8'h08, 32'h00ff_7e10);
    for (int i = 0; i < 2; i++)
    begin
      transmit_bit_input <= i[0];
      repeat (3) @(posedge clk_sys);
      chk("synth", i ? 32'h12_3852 : 32'h12_305a, tx_ctrl.synth_div);
      chk("power", 32'h3f, tx_ctrl.pa_power);
    end
    chk("bias", 32'h0, tx_ctrl.pa_bias);
    chk("pa_on", 32'h1, tx_ctrl.pa_enable);
    chk("lna_short", 32'h1, front_ctrl.lna_short);
    wr(8'h08, 32'h00ff_7e40);
    chk("mod", 32'h1, tx_ctrl.mod_scheme);
    chk("pa_off", 32'h0, tx_ctrl.pa_enable);
    chk("centre", 32'h12_3456, tx_ctrl.synth_div);
    wr(8'h00, 32'h0800_0000);
    chk("lna_open", 32'h0, front_ctrl.lna_short);
    $display("test transmit done");
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h04, i << 22);
      chk("lpf_bw", i, front_ctrl.lpf_bw);
    end
    fmgd_host_model_inst.cal(32'h0a5c_8580, n);
    chk("cal_len", 32'h15, n);
    chk("divider", 32'h0a5, lpf_divider);
    chk("corr_bw", 32'h58, correlator_bandwidth);
    chk("noise", 32'h1, front_ctrl.amp_noise_mode_bit);
    chk("mixer", 32'h1, front_ctrl.mixer_linear);
    $display("test front end done");
    wr(8'h24, 32'h0060_4640);
    chk("amp_man", 32'h2, front_ctrl.front_amp_gain_field);
    chk("filt_man", 32'h1, front_ctrl.filter_gain);
    wr(8'h0c, 32'h0000_fa00);
    strength_code <= 7'h7f;
    wr(8'h24, 32'h000e_78f0);
    repeat (16000) @(posedge clk_sys);
    chk("amp_low", 32'h0, front_ctrl.front_amp_gain_field);
    chk("filt_low", 32'h0, front_ctrl.filter_gain);
    rd(8'h30, 32'h7f);
    strength_code <= 7'h00;
    repeat (16000) @(posedge clk_sys);
    chk("amp_high", 32'h3, front_ctrl.front_amp_gain_field);
    chk("filt_high", 32'h2, front_ctrl.filter_gain);
    $display("test gain loop done");
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h0c, 32'h0000_fa00 | (i << 4));
      per(n);
      chk("offset_period", 4 << i, n);
    end
    bit_chk(32'h0000_8010, 12'sd1000, 1'b1);
    bit_chk(32'h0000_8000, 12'sd1000, 1'b0);
    bit_chk(32'h0000_8010, -12'sd1000, 1'b0);
    $display("test demod done");
    results();
  end
endmodule : tb
